// File: src/icc_pkg.sv
/*
 * Constants for the input capture channel: register map, control field
 * positions, reset values and capture mode encodings.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package icc_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_BUF = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int CTRL_IDLE_STOP_BIT = 13;
    localparam int CTRL_TIMER_SEL_BIT = 7;
    localparam int CTRL_CPI_LSB = 5;
    localparam int CTRL_OVF_BIT = 4;
    localparam int CTRL_BNE_BIT = 3;
    localparam int CTRL_MODE_LSB = 0;

    // Interrupt status bit positions
    localparam int IRQ_CAPTURE_BIT = 0;
    localparam int IRQ_OVERFLOW_BIT = 1;
    localparam int IRQ_WAKE_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] CPI_RESET = 2'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] PRESCALE_4 = 4'h3;
    localparam logic [3:0] PRESCALE_16 = 4'hf;

    // ----------------------------------------------------------------
    // Capture modes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
    localparam logic [2:0] MODE_FALL = 3'h2;
    localparam logic [2:0] MODE_RISE = 3'h3;
    localparam logic [2:0] MODE_RISE_4 = 3'h4;
    localparam logic [2:0] MODE_RISE_16 = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h6;
    localparam logic [2:0] MODE_WAKE = 3'h7;

endpackage : icc_pkg

// File: src/icc_fifo.sv
/*
 * Four-entry capture buffer holding 16-bit timer values.
 * Assumes push and pop come from logic on clk_i; push while full is dropped.
 */
module icc_fifo (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [15:0] data_i,
    input wire logic pop_i,
    output logic [15:0] data_o,
    output logic empty_o,
    output logic full_o
);

    logic [15:0] mem [0:icc_pkg::FIFO_DEPTH-1];
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] count;

    wire do_push = push_i && !full_o;
    wire do_pop = pop_i && !empty_o;

    assign empty_o = (count == 3'h0);
    assign full_o = (count == 3'h4);
    assign data_o = mem[rd_ptr];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            count <= 3'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 2'h1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 2'h1;
            end
            if (do_push && !do_pop) begin
                count <= count + 3'h1;
            end else if (do_pop && !do_push) begin
                count <= count - 3'h1;
            end
        end
    end

endmodule : icc_fifo

// File: src/icc_channel.sv
/*
 * Input capture channel: edge detection and prescaling on the capture pin,
 * timer capture into a four-entry buffer, interrupt pacing, wake request,
 * and a classic Wishbone register slave.
 * Assumes both timer counts arrive on clk_i; the capture pin and the
 * processor power states are asynchronous and synchronised here.
 */
// Chosen here: register access over Wishbone and the placing of the registers.
// Summary of operation
// - A qualifying pin event latches the selected timer's 16-bit count.
// - Timer select one takes the first timer, zero the second.
// - Captures-per-interrupt field: interrupt every 1st, 2nd, 3rd or 4th capture.
// - Every-edge mode ignores captures-per-interrupt; each capture interrupts.
// - Read-only overflow flag reads one after a capture overflow.
// - Read-only not-empty flag reads one while unread captures remain.
// - Captures are held in a four-deep first-in first-out buffer.
// - Mode 111 is a rising-edge interrupt only in Sleep or Idle.
// - Mode 000 is off; mode 110 is unused and disabled.
// - Mode 101 captures every 16th rising edge, 100 every 4th.
// - Mode 011 captures every rising edge, 010 every falling edge.
// - Mode 001 captures on both rising and falling edges.
// - Idle-stop set halts the channel in Idle; clear keeps it running.
// - A capture pin event can wake the device from Sleep and Idle.
module icc_channel (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Capture side
    input wire logic capture_input_pin_i,
    input wire logic [15:0] first_timer_count_i,
    input wire logic [15:0] second_timer_count_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    output logic wake_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // Control and synchronisers
    // ----------------------------------------------------------------
    logic capture_idle_stop;
    logic capture_timer_select;
    logic [1:0] captures_per_interrupt;
    logic [2:0] capture_mode_select;
    logic capture_overflow_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] pin_sync;
    logic [1:0] idle_sync;
    logic [1:0] sleep_sync;
    logic [3:0] prescale_count;
    logic [1:0] event_count;
    logic [15:0] fifo_data;
    logic fifo_empty;
    logic fifo_full;

    // Bit 0 is the metastable stage; only bit 1 reads it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync <= 3'h0;
            idle_sync <= 2'h0;
            sleep_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], capture_input_pin_i};
            idle_sync <= {idle_sync[0], cpu_idle_i};
            sleep_sync <= {sleep_sync[0], cpu_sleep_i};
        end
    end

    wire pin_rise = pin_sync[1] && !pin_sync[2];
    wire pin_fall = !pin_sync[1] && pin_sync[2];
    wire in_idle = idle_sync[1];
    wire in_sleep = sleep_sync[1];

    // ----------------------------------------------------------------
    // Event qualification
    // ----------------------------------------------------------------
    wire halted = capture_idle_stop && in_idle;
    wire mode_off = (capture_mode_select == icc_pkg::MODE_OFF)
        || (capture_mode_select == icc_pkg::MODE_UNUSED);
    wire mode_wake = (capture_mode_select == icc_pkg::MODE_WAKE);
    wire mode_every = (capture_mode_select == icc_pkg::MODE_EVERY_EDGE);
    wire mode_presc4 = (capture_mode_select == icc_pkg::MODE_RISE_4);
    wire mode_presc16 = (capture_mode_select == icc_pkg::MODE_RISE_16);
    wire [3:0] prescale_top = mode_presc16 ? icc_pkg::PRESCALE_16 : icc_pkg::PRESCALE_4;
    wire prescale_hit = pin_rise && (prescale_count == prescale_top);

    logic capture_event;
    always_comb begin
        capture_event = 1'b0;
        case (capture_mode_select)
            icc_pkg::MODE_EVERY_EDGE: capture_event = pin_rise || pin_fall;
            icc_pkg::MODE_FALL: capture_event = pin_fall;
            icc_pkg::MODE_RISE: capture_event = pin_rise;
            icc_pkg::MODE_RISE_4: capture_event = prescale_hit;
            icc_pkg::MODE_RISE_16: capture_event = prescale_hit;
            default: capture_event = 1'b0;
        endcase
        if (halted) begin
            capture_event = 1'b0;
        end
    end

    // Rising edge only, and only while the processor sleeps or idles
    wire wake_event = mode_wake && pin_rise && (in_sleep || in_idle);
    wire capture_value_sel = capture_timer_select;
    wire [15:0] capture_value = capture_value_sel ? first_timer_count_i
        : second_timer_count_i;
    wire capture_drop = capture_event && fifo_full;

    always_ff @(posedge clk_i) begin
        if (rst_i || mode_off) begin
            prescale_count <= 4'h0;
        end else if (!halted && (mode_presc4 || mode_presc16) && pin_rise) begin
            prescale_count <= prescale_hit ? 4'h0 : prescale_count + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pacing
    // ----------------------------------------------------------------
    wire pace_hit = mode_every || (event_count == captures_per_interrupt);
    wire capture_irq = capture_event && !fifo_full && pace_hit;

    always_ff @(posedge clk_i) begin
        if (rst_i || mode_off) begin
            event_count <= 2'h0;
        end else if (capture_event && !fifo_full && !mode_every) begin
            event_count <= pace_hit ? 2'h0 : event_count + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Capture buffer
    // ----------------------------------------------------------------
    wire bus_req = cyc_i && stb_i && !ack_o;
    wire bus_rd = bus_req && !we_i;
    wire bus_wr = bus_req && we_i;
    wire hit_ctrl = (adr_i == icc_pkg::ADDR_CTRL);
    wire hit_buf = (adr_i == icc_pkg::ADDR_BUF);
    wire hit_stat = (adr_i == icc_pkg::ADDR_IRQ_STAT);
    wire hit_mask = (adr_i == icc_pkg::ADDR_IRQ_MASK);
    wire buf_pop = bus_rd && hit_buf;

    icc_fifo u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(mode_off),
        .push_i(capture_event),
        .data_i(capture_value),
        .pop_i(buf_pop),
        .data_o(fifo_data),
        .empty_o(fifo_empty),
        .full_o(fifo_full)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || mode_off) begin
            capture_overflow_flag <= 1'b0;
        end else if (capture_drop) begin
            capture_overflow_flag <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    wire [15:0] ctrl_view = {2'h0, capture_idle_stop, 5'h00, capture_timer_select,
        captures_per_interrupt, capture_overflow_flag, !fifo_empty,
        capture_mode_select};

    wire [31:0] read_mux = hit_ctrl ? {16'h0000, ctrl_view}
        : hit_buf ? {16'h0000, fifo_data}
        : hit_stat ? {29'h0, irq_status}
        : hit_mask ? {29'h0, irq_mask}
        : 32'h0000_0000;

    wire ctrl_wr_lo = bus_wr && hit_ctrl && sel_i[0];
    wire ctrl_wr_hi = bus_wr && hit_ctrl && sel_i[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_rd ? read_mux : 32'h0000_0000;
        end
    end

    // Flag bits 4 and 3 are read-only; writes to them are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_idle_stop <= 1'b0;
            capture_timer_select <= 1'b0;
            captures_per_interrupt <= icc_pkg::CPI_RESET;
            capture_mode_select <= icc_pkg::MODE_RESET;
            irq_mask <= icc_pkg::IRQ_MASK_RESET;
        end else begin
            if (ctrl_wr_hi) begin
                capture_idle_stop <= dat_i[icc_pkg::CTRL_IDLE_STOP_BIT];
            end
            if (ctrl_wr_lo) begin
                capture_timer_select <= dat_i[icc_pkg::CTRL_TIMER_SEL_BIT];
                captures_per_interrupt <= dat_i[icc_pkg::CTRL_CPI_LSB +: 2];
                capture_mode_select <= dat_i[icc_pkg::CTRL_MODE_LSB +: 3];
            end
            if (bus_wr && hit_mask && sel_i[0]) begin
                irq_mask <= dat_i[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status: set wins over the clear-on-read
    // ----------------------------------------------------------------
    wire [2:0] irq_set = {wake_event, capture_drop, capture_irq};
    wire stat_read = bus_rd && hit_stat;
    wire [2:0] next_irq_status = (stat_read ? 3'h0 : irq_status) | irq_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign irq_o = |(irq_status & irq_mask);
    // Wake follows the unmasked event bits so a sleeping core can resume
    assign wake_o = in_sleep || in_idle ? |irq_status : 1'b0;

endmodule : icc_channel

// File: bench/icc_properties.sv
/* Port checker for icc_channel: bus timing, register read-back, interrupt gating.
   Assumes one clock, bound to the channel's own ports. */
module icc_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic wake_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // Shadow of the writable control bits and the mask
    // ----------------------------------------------------------------
    logic [15:0] ctrl_sh;
    logic [2:0] mask_sh;
    wire logic take = cyc_i && stb_i && !ack_o;
    wire logic wr = take && we_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_sh <= 16'h0000;
            mask_sh <= 3'h0;
        end else begin
            if (wr && adr_i == icc_pkg::ADDR_CTRL && sel_i[0]) begin
                ctrl_sh[7:0] <= dat_i[7:0] & 8'he7;
            end
            if (wr && adr_i == icc_pkg::ADDR_CTRL && sel_i[1]) begin
                ctrl_sh[13] <= dat_i[13];
            end
            if (wr && adr_i == icc_pkg::ADDR_IRQ_MASK && sel_i[0]) begin
                mask_sh <= dat_i[2:0];
            end
        end
    end
    sequence s_rd(logic [3:0] a);
        take && !we_i && adr_i == a;
    endsequence
    property p_ack_next; take |=> ack_o; endproperty
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    property p_unmapped; take && !we_i && adr_i[1:0] != 2'h0 |=> dat_o == 32'h0; endproperty
    property p_ctrl_rsvd; s_rd(icc_pkg::ADDR_CTRL) |=> (dat_o & 32'hffffdf00) == 32'h0; endproperty
    property p_ctrl_back;
        s_rd(icc_pkg::ADDR_CTRL) |=> (dat_o[15:0] & 16'h20e7) == ctrl_sh;
    endproperty
    property p_off_flags;
        s_rd(icc_pkg::ADDR_CTRL) ##0 (ctrl_sh[2:0] == icc_pkg::MODE_OFF ||
            ctrl_sh[2:0] == icc_pkg::MODE_UNUSED) |=> dat_o[4:3] == 2'h0;
    endproperty
    property p_mask_gate; mask_sh == 3'h0 |-> !irq_o; endproperty
    // Two sync flops on the power states, so four quiet samples suffice
    property p_wake_quiet; (!cpu_sleep_i && !cpu_idle_i) [*4] |-> !wake_o; endproperty
    property p_irq_fall; $fell(irq_o) |-> ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits set");
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback");
    a_off_flags: assert property (p_off_flags) else $error("flags while off");
    a_mask_gate: assert property (p_mask_gate) else $error("irq while masked");
    a_wake_quiet: assert property (p_wake_quiet) else $error("wake while awake");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule : icc_properties

// File: bench/icc_pin_model.sv
/* Far-side source of the capture pin.
   Assumes the bench calls toggle; pin rests low after reset. */
module icc_pin_model (
    input wire logic clk_i,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pin_o = 1'b0;
    end
    // A larger hold models a slow source
    task automatic toggle(input int hold);
        @(posedge clk_i);
        pin_o <= ~pin_o;
        repeat (hold) @(posedge clk_i);
    endtask : toggle
endmodule : icc_pin_model

// File: bench/input_capture_channel_bench.sv
/* Self-checking bench for icc_channel.
   Assumes the one-cycle Wishbone answer of the channel and 25 MHz clock. */
module input_capture_channel_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, idle, sleep;
    logic [3:0] adr_i, sel_i;
    logic [31:0] dat_i, rd;
    logic [15:0] t1, t2;
    logic [15:0] expq[$];
    wire logic pin, ack_o, wake_o, irq_o;
    wire logic [31:0] dat_o;
    int n_mismatch, checked, n;
    icc_pin_model pin_u (.clk_i(clk_i), .pin_o(pin));
    icc_channel dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .capture_input_pin_i(pin), .first_timer_count_i(t1),
        .second_timer_count_i(t2), .cpu_idle_i(idle), .cpu_sleep_i(sleep),
        .wake_o(wake_o), .irq_o(irq_o));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        checked++;
        if (got !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (ack_o !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : bus
    task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
        input string s);
        bus(1'b0, a, 32'h0);
        chk(s, e, rd & m);
    endtask : rc
    // Timer counts step with each pin change so a capture names its edge
    task automatic edges(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk_i);
            t1 <= 16'h1000 + 16'(i);
            t2 <= 16'h2000 + 16'(i);
            pin_u.toggle(6);
        end
    endtask : edges
    task automatic drain;
        while (expq.size() > 0) begin
            rc(icc_pkg::ADDR_CTRL, 32'h8, 32'h8, "not_empty");
            rc(icc_pkg::ADDR_BUF, 32'hffff, {16'h0, expq.pop_front()}, "capture");
        end
        rc(icc_pkg::ADDR_CTRL, 32'h8, 32'h0, "emptied");
    endtask : drain
    function automatic bit qual(input logic [2:0] m, input int i);
        case (m)
            icc_pkg::MODE_EVERY_EDGE: return 1'b1;
            icc_pkg::MODE_FALL: return i % 2 == 1;
            icc_pkg::MODE_RISE: return i % 2 == 0;
            icc_pkg::MODE_RISE_4: return i % 8 == 6;
            icc_pkg::MODE_RISE_16: return i % 32 == 30;
            default: return 1'b0;
        endcase
    endfunction : qual
    initial begin
        {rst_i, cyc_i, stb_i, we_i, idle, sleep} = 6'h20;
        {adr_i, sel_i, dat_i, t1, t2} = {8'h0f, 64'h0};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(icc_pkg::ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl_reset");
        rc(icc_pkg::ADDR_IRQ_MASK, 32'hffffffff, 32'h0, "mask_reset");
        bus(1'b1, 4'h2, 32'hffffffff);
        rc(4'h2, 32'hffffffff, 32'h0, "unmapped");
        rc(icc_pkg::ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl_untouched");
        for (int m = 0; m < 7; m++) begin
            n = (m == 5) ? 32 : (m == 4) ? 8 : 4;
            bus(1'b1, icc_pkg::ADDR_CTRL, {24'h0, m[0], 4'h0, m[2:0]});
            for (int i = 0; i < n; i++) begin
                if (qual(m[2:0], i)) expq.push_back((m[0] ? 16'h1000 : 16'h2000) + 16'(i));
            end
            edges(n);
            drain();
            bus(1'b1, icc_pkg::ADDR_CTRL, 32'h0);
        end
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h3);
        for (int i = 0; i < 4; i++) expq.push_back(16'h2000 + 16'(2 * i));
        edges(10);
        rc(icc_pkg::ADDR_CTRL, 32'h18, 32'h18, "overflow");
        drain();
        rc(icc_pkg::ADDR_CTRL, 32'h10, 32'h10, "overflow_held");
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h0);
        rc(icc_pkg::ADDR_CTRL, 32'h10, 32'h0, "overflow_cleared");
        bus(1'b1, icc_pkg::ADDR_IRQ_MASK, 32'h7);
        bus(1'b0, icc_pkg::ADDR_IRQ_STAT, 32'h0);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, icc_pkg::ADDR_CTRL, {25'h0, c[1:0], 5'h3});
            for (int r = 0; r <= c; r++) begin
                edges(2);
                chk("irq_pace", {31'h0, r == c}, {31'h0, irq_o});
            end
            rc(icc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h1, "status");
            chk("irq_cleared", 32'h0, {31'h0, irq_o});
            bus(1'b1, icc_pkg::ADDR_CTRL, 32'h0);
        end
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h61);
        edges(1);
        chk("irq_every_edge", 32'h1, {31'h0, irq_o});
        bus(1'b1, icc_pkg::ADDR_IRQ_MASK, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        rc(icc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h1, "status_masked");
        rc(icc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h0, "status_read_clears");
        edges(1);
        idle <= 1'b1;
        // Every-edge captures are still buffered; empty it before the halt check
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h0);
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h2003);
        edges(2);
        rc(icc_pkg::ADDR_CTRL, 32'h8, 32'h0, "idle_halt");
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h0003);
        edges(2);
        rc(icc_pkg::ADDR_CTRL, 32'h8, 32'h8, "idle_run");
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h0);
        idle <= 1'b0;
        sleep <= 1'b1;
        bus(1'b1, icc_pkg::ADDR_IRQ_MASK, 32'h7);
        bus(1'b0, icc_pkg::ADDR_IRQ_STAT, 32'h0);
        bus(1'b1, icc_pkg::ADDR_CTRL, 32'h7);
        edges(2);
        chk("wake", 32'h1, {31'h0, wake_o});
        rc(icc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h4, "wake_status");
        rc(icc_pkg::ADDR_CTRL, 32'h8, 32'h0, "wake_no_capture");
        sleep <= 1'b0;
        edges(2);
        rc(icc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h0, "awake_no_event");
        conclude();
    end
endmodule : input_capture_channel_bench
bind icc_channel icc_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i),
    .wake_o(wake_o), .irq_o(irq_o));
